// ---- shared/i2c_status_pkg.sv ----
// Constants and carrier types for the two-wire bus status and address mask block
package i2c_status_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // Register offsets (word index on the plain register port)
   localparam logic [2:0] OFF_STATUS   = 3'h0;
   localparam logic [2:0] OFF_MASK     = 3'h1;
   localparam logic [2:0] OFF_TX_HOLD  = 3'h2;
   localparam logic [2:0] OFF_RX_HOLD  = 3'h3;
   localparam logic [2:0] OFF_IRQ_STAT = 3'h4;
   localparam logic [2:0] OFF_IRQ_MASK = 3'h5;

   // Status register field positions
   localparam int BIT_ACK_STATE  = 15;
   localparam int BIT_TX_ACTIVE  = 14;
   localparam int BIT_COLLISION  = 10;
   localparam int BIT_GCALL      = 9;
   localparam int BIT_TEN_MATCH  = 8;
   localparam int BIT_WR_CLASH   = 7;
   localparam int BIT_RX_OVF     = 6;
   localparam int BIT_DATA_ADDR  = 5;
   localparam int BIT_STOP       = 4;
   localparam int BIT_START      = 3;
   localparam int BIT_READ_DIR   = 2;
   localparam int BIT_RX_FULL    = 1;
   localparam int BIT_TX_FULL    = 0;

   localparam int MASK_W = 10;

   // Interrupt status / mask field positions
   localparam int IRQ_N         = 6;
   localparam int IRQ_START     = 0;
   localparam int IRQ_STOP      = 1;
   localparam int IRQ_RX_BYTE   = 2;
   localparam int IRQ_COLLISION = 3;
   localparam int IRQ_RX_OVF    = 4;
   localparam int IRQ_WR_CLASH  = 5;

   // Reset values
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [9:0]  MASK_RST   = 10'h000;
   localparam logic [5:0]  IRQ_RST    = 6'h00;

   // Bus framing constants
   localparam logic [3:0] ACK_SLOT_CNT = 4'h8;
   localparam logic [3:0] LAST_BIT_CNT = 4'h7;
   localparam logic [4:0] TEN_BIT_HDR  = 5'h1e;
   localparam logic [7:0] GCALL_ADDR   = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef enum logic [4:0] {
      st_idle    = 5'b00001,
      st_addr    = 5'b00010,
      st_addr_lo = 5'b00100,
      st_data    = 5'b01000,
      st_skip    = 5'b10000
   } bus_phase_t;

endpackage

// ---- rtl/i2c_status_mask.sv ----
// Status flags, address mask matching and register port of a two-wire bus controller
// What this block does
// - Record slave ACK/NACK on the acknowledge slot clock rise
// - Transmit-active flag spans eight bits plus ACK
// - Bus collision sets sticky flag until cleared
// - General call match sets flag, Stop clears
// - Ten-bit second byte match sets flag
// - Transmit write while busy fails, sets clash
// - Receive while holding full sets overflow flag
// - Address match clears, slave data sets flag
// - Stop sets stop flag, Start clears it
// - Start sets start flag, Stop clears it
// - Latch read/write direction from address byte
// - Receive full set on load, cleared by read
// - Transmit full set on write, cleared after send
// - Set mask bits ignore address bits in matching
// - Unused bits read zero, all reset zero
//
// Implementation choices: the register offsets and the strobed register port.
module i2c_status_mask (
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire i2c_status_pkg::reg_req_t bus,
   output logic [15:0]                  rd_data,
   input  wire logic                    scl_pin,
   input  wire logic                    sda_pin,
   input  wire logic [9:0]              own_address,
   input  wire logic                    ten_bit_mode,
   input  wire logic                    gc_enable,
   input  wire logic                    master_mode,
   input  wire logic                    master_rx_active,
   input  wire logic                    master_tx_begin,
   input  wire logic                    bus_collision,
   input  wire logic                    module_busy,
   output logic [7:0]                   tx_data,
   output logic                         irq
);

   logic        scl_s1, scl_s2, scl_d;
   logic        sda_s1, sda_s2, sda_d;
   logic [3:0]  bit_cnt;
   logic [7:0]  rx_shift_reg;
   logic [7:0]  rx_holding_reg;
   logic [9:0]  address_bit_ignore;
   logic [5:0]  irq_status;
   logic [5:0]  irq_mask;
   i2c_status_pkg::bus_phase_t phase, next_phase;

   logic ack_from_slave_state, master_tx_active, bus_collision_flag;
   logic general_call_seen, ten_bit_match_flag, tx_write_clash, rx_overflow_flag;
   logic data_not_address, stop_detected, start_detected, slave_read_dir;
   logic rx_holding_full, tx_holding_full;

   // Pin synchronisers: only the second stage and its delayed copy are examined
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_pin;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_pin;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   logic scl_rise, start_det, stop_det, byte_done, ack_slot;
   logic [7:0] new_byte;
   assign scl_rise  = scl_s2 & ~scl_d;
   assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign byte_done = scl_rise & (bit_cnt == i2c_status_pkg::LAST_BIT_CNT);
   assign ack_slot  = scl_rise & (bit_cnt == i2c_status_pkg::ACK_SLOT_CNT);
   assign new_byte  = {rx_shift_reg[6:0], sda_s2};

   // Bit position within the frame: eight data bits then the acknowledge slot
   always_ff @(posedge ref_clk) begin
      if (srst || start_det || stop_det) begin
         bit_cnt <= 4'h0;
      end else if (ack_slot) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_shift_reg <= 8'h00;
      end else if (scl_rise && !ack_slot) begin
         rx_shift_reg <= new_byte;
      end
   end

   // Masked comparison: a set ignore bit lets that address bit differ
   logic hit7, gc_hit, hdr_hit, lo_hit, full_match;
   assign hit7    = ~ten_bit_mode &
                    (((new_byte[7:1] ^ own_address[6:0]) & ~address_bit_ignore[6:0]) == 7'h00);
   assign gc_hit  = gc_enable & (new_byte == i2c_status_pkg::GCALL_ADDR);
   assign hdr_hit = ten_bit_mode & (new_byte[7:3] == i2c_status_pkg::TEN_BIT_HDR) &
                    (((new_byte[2:1] ^ own_address[9:8]) & ~address_bit_ignore[9:8]) == 2'h0);
   assign lo_hit  = ((new_byte ^ own_address[7:0]) & ~address_bit_ignore[7:0]) == 8'h00;

   // A ten-bit read restart repeats only the header, so it completes the match when the ten-bit match flag is already set
   assign full_match = byte_done & (
      ((phase == i2c_status_pkg::st_addr) & ~master_mode &
       (hit7 | gc_hit | (hdr_hit & new_byte[0] & ten_bit_match_flag))) |
      ((phase == i2c_status_pkg::st_addr_lo) & lo_hit));

   always_comb begin
      next_phase = phase;
      unique case (phase)
         i2c_status_pkg::st_idle: next_phase = phase;
         i2c_status_pkg::st_addr: begin
            if (byte_done) begin
               if (full_match) begin
                  next_phase = i2c_status_pkg::st_data;
               end else if (hdr_hit && !master_mode) begin
                  next_phase = i2c_status_pkg::st_addr_lo;
               end else begin
                  next_phase = i2c_status_pkg::st_skip;
               end
            end
         end
         i2c_status_pkg::st_addr_lo: begin
            if (byte_done) begin
               next_phase = lo_hit ? i2c_status_pkg::st_data : i2c_status_pkg::st_skip;
            end
         end
         i2c_status_pkg::st_data: next_phase = phase;
         i2c_status_pkg::st_skip: next_phase = phase;
      endcase
      if (start_det) begin
         next_phase = i2c_status_pkg::st_addr;
      end
      if (stop_det) begin
         next_phase = i2c_status_pkg::st_idle;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase <= i2c_status_pkg::st_idle;
      end else begin
         phase <= next_phase;
      end
   end

   // Register port decode
   logic wr_status, wr_mask, wr_tx, rd_rx, wr_irq_stat, wr_irq_mask;
   assign wr_status   = bus.wr & (bus.addr == i2c_status_pkg::OFF_STATUS);
   assign wr_mask     = bus.wr & (bus.addr == i2c_status_pkg::OFF_MASK);
   assign wr_tx       = bus.wr & (bus.addr == i2c_status_pkg::OFF_TX_HOLD);
   assign rd_rx       = bus.rd & (bus.addr == i2c_status_pkg::OFF_RX_HOLD);
   assign wr_irq_stat = bus.wr & (bus.addr == i2c_status_pkg::OFF_IRQ_STAT);
   assign wr_irq_mask = bus.wr & (bus.addr == i2c_status_pkg::OFF_IRQ_MASK);

   logic slave_data_ev, load_rx, load_ok, ovf_ev, clash_ev, tx_accept, tx_done;
   assign slave_data_ev = byte_done & (phase == i2c_status_pkg::st_data) & ~slave_read_dir;
   assign load_rx   = slave_data_ev | (byte_done & master_rx_active);
   // A read in the same cycle frees the holding register, so the byte is not lost
   assign load_ok   = load_rx & (~rx_holding_full | rd_rx);
   assign ovf_ev    = load_rx & rx_holding_full & ~rd_rx;
   assign clash_ev  = wr_tx & (module_busy | tx_holding_full);
   assign tx_accept = wr_tx & ~clash_ev;
   assign tx_done   = ack_slot & (master_tx_active |
                      ((phase == i2c_status_pkg::st_data) & slave_read_dir));

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_from_slave_state <= 1'b0;
      end else if (ack_slot && master_tx_active) begin
         ack_from_slave_state <= sda_s2;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         master_tx_active <= 1'b0;
      end else if (master_tx_begin) begin
         master_tx_active <= 1'b1;
      end else if (ack_slot) begin
         master_tx_active <= 1'b0;
      end
   end

   // Sticky errors: hardware set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_collision_flag <= 1'b0;
         tx_write_clash     <= 1'b0;
         rx_overflow_flag   <= 1'b0;
      end else begin
         if (bus_collision) begin
            bus_collision_flag <= 1'b1;
         end else if (wr_status && !bus.wdata[i2c_status_pkg::BIT_COLLISION]) begin
            bus_collision_flag <= 1'b0;
         end
         if (clash_ev) begin
            tx_write_clash <= 1'b1;
         end else if (wr_status && !bus.wdata[i2c_status_pkg::BIT_WR_CLASH]) begin
            tx_write_clash <= 1'b0;
         end
         if (ovf_ev) begin
            rx_overflow_flag <= 1'b1;
         end else if (wr_status && !bus.wdata[i2c_status_pkg::BIT_RX_OVF]) begin
            rx_overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || stop_det) begin
         general_call_seen  <= 1'b0;
         ten_bit_match_flag <= 1'b0;
      end else begin
         if (full_match && gc_hit && phase == i2c_status_pkg::st_addr) begin
            general_call_seen <= 1'b1;
         end
         if (byte_done && phase == i2c_status_pkg::st_addr_lo && lo_hit) begin
            ten_bit_match_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         data_not_address <= 1'b0;
      end else if (full_match) begin
         data_not_address <= 1'b0;
      end else if (slave_data_ev) begin
         data_not_address <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stop_detected  <= 1'b0;
         start_detected <= 1'b0;
      end else if (stop_det) begin
         stop_detected  <= 1'b1;
         start_detected <= 1'b0;
      end else if (start_det) begin
         start_detected <= 1'b1;
         stop_detected  <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         slave_read_dir <= 1'b0;
      end else if (byte_done && phase == i2c_status_pkg::st_addr && !master_mode) begin
         slave_read_dir <= new_byte[0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_holding_full <= 1'b0;
         rx_holding_reg  <= 8'h00;
      end else if (load_ok) begin
         rx_holding_full <= 1'b1;
         rx_holding_reg  <= new_byte;
      end else if (rd_rx) begin
         rx_holding_full <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tx_holding_full <= 1'b0;
         tx_data         <= 8'h00;
      end else if (tx_accept) begin
         tx_holding_full <= 1'b1;
         tx_data         <= bus.wdata[7:0];
      end else if (tx_done) begin
         tx_holding_full <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         address_bit_ignore <= i2c_status_pkg::MASK_RST;
         irq_mask           <= i2c_status_pkg::IRQ_RST;
      end else begin
         if (wr_mask) begin
            address_bit_ignore <= bus.wdata[i2c_status_pkg::MASK_W-1:0];
         end
         if (wr_irq_mask) begin
            irq_mask <= bus.wdata[i2c_status_pkg::IRQ_N-1:0];
         end
      end
   end

   // Interrupt events: set wins over a write-one clear
   logic [5:0] irq_ev;
   always_comb begin
      irq_ev = 6'h00;
      irq_ev[i2c_status_pkg::IRQ_START]     = start_det;
      irq_ev[i2c_status_pkg::IRQ_STOP]      = stop_det;
      irq_ev[i2c_status_pkg::IRQ_RX_BYTE]   = load_ok;
      irq_ev[i2c_status_pkg::IRQ_COLLISION] = bus_collision;
      irq_ev[i2c_status_pkg::IRQ_RX_OVF]    = ovf_ev;
      irq_ev[i2c_status_pkg::IRQ_WR_CLASH]  = clash_ev;
   end

   for (genvar i = 0; i < i2c_status_pkg::IRQ_N; i++) begin : g_irq
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            irq_status[i] <= 1'b0;
         end else if (irq_ev[i]) begin
            irq_status[i] <= 1'b1;
         end else if (wr_irq_stat && bus.wdata[i]) begin
            irq_status[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   logic [15:0] status_word;
   assign status_word = {ack_from_slave_state, master_tx_active, 3'h0, bus_collision_flag,
                         general_call_seen, ten_bit_match_flag, tx_write_clash,
                         rx_overflow_flag, data_not_address, stop_detected,
                         start_detected, slave_read_dir, rx_holding_full,
                         tx_holding_full};

   // Read data stand for exactly one cycle; unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (srst || !bus.rd) begin
         rd_data <= 16'h0000;
      end else begin
         unique case (bus.addr)
            i2c_status_pkg::OFF_STATUS:   rd_data <= status_word;
            i2c_status_pkg::OFF_MASK:     rd_data <= {6'h00, address_bit_ignore};
            i2c_status_pkg::OFF_TX_HOLD:  rd_data <= {8'h00, tx_data};
            i2c_status_pkg::OFF_RX_HOLD:  rd_data <= {8'h00, rx_holding_reg};
            i2c_status_pkg::OFF_IRQ_STAT: rd_data <= {10'h000, irq_status};
            i2c_status_pkg::OFF_IRQ_MASK: rd_data <= {10'h000, irq_mask};
            default:                      rd_data <= 16'h0000;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_after_stop;
      stop_detected && !start_detected && !general_call_seen && !ten_bit_match_flag;
   endsequence

   a_ack_record: assert property (ack_slot && master_tx_active |=>
      ack_from_slave_state == $past(sda_s2)) else $error("ack result not recorded");
   a_tx_active_span: assert property (master_tx_begin ||
      (master_tx_active && !ack_slot) |=> master_tx_active)
      else $error("transmit active dropped early");
   a_tx_active_end: assert property (ack_slot && !master_tx_begin |=>
      !master_tx_active) else $error("transmit active not cleared");
   a_collision_sticky: assert property (bus_collision_flag && !wr_status
      |=> bus_collision_flag) else $error("collision flag lost");
   a_collision_set: assert property (bus_collision |=> bus_collision_flag)
      else $error("collision flag not set");
   a_stop_clears: assert property (stop_det |=> s_after_stop)
      else $error("stop effects missing");
   a_start_flag: assert property (start_det && !stop_det |=>
      start_detected && !stop_detected) else $error("start flag wrong");
   a_write_clash: assert property (wr_tx && module_busy |=> tx_write_clash &&
      $stable(tx_data)) else $error("busy write not refused");
   a_rx_overflow: assert property (load_rx && rx_holding_full && !rd_rx |=>
      rx_overflow_flag && $stable(rx_holding_reg)) else $error("overflow not flagged");
   a_match_clears: assert property (full_match |=> !data_not_address &&
      phase == i2c_status_pkg::st_data) else $error("match not taken");
   a_read_dir: assert property (byte_done && phase == i2c_status_pkg::st_addr &&
      !master_mode |=> slave_read_dir == $past(sda_s2)) else $error("direction not latched");
   a_rx_full_read: assert property (rd_rx && !load_rx |=> !rx_holding_full)
      else $error("read did not empty holding");
   a_tx_full_write: assert property (tx_accept |=> tx_holding_full &&
      tx_data == $past(bus.wdata[7:0])) else $error("transmit write lost");
   a_mask_ignore: assert property (byte_done && phase == i2c_status_pkg::st_addr &&
      !master_mode && !ten_bit_mode && !stop_det && !start_det &&
      ((new_byte[7:1] ^ own_address[6:0]) & ~address_bit_ignore[6:0]) == 7'h00
      |=> phase == i2c_status_pkg::st_data) else $error("masked address missed");
   a_reserved_zero: assert property ($past(bus.rd) &&
      $past(bus.addr) == i2c_status_pkg::OFF_STATUS |-> rd_data[13:11] == 3'h0)
      else $error("reserved status bits set");

endmodule // i2c_status_mask

// ---- bench/i2c_bus_model.sv ----
// Behavioural far-side bus party that drives the clock and data lines
module i2c_bus_model (
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   // Lines rest high through the pull-ups; the clock stands still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Also serves as a repeated start when entered with the clock low
   task automatic start_cond();
      sda = 1'b1;
      #80 scl = 1'b1;
      #80 sda = 1'b0;
      #80 scl = 1'b0;
      #80;
   endtask

   // 320 ns bit period; data only moves while the clock is low
   task automatic bit_out(input logic b);
      sda = b;
      #80 scl = 1'b1;
      #160 scl = 1'b0;
      #80;
   endtask

   task automatic byte_out(input logic [7:0] b, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i]);
      end
      bit_out(ack);
      sda = 1'b1;
   endtask

   task automatic stop_cond();
      sda = 1'b0;
      #80 scl = 1'b1;
      #80 sda = 1'b1;
      #80;
   endtask
endmodule // i2c_bus_model

// ---- bench/tb_i2c_status_and_address_mask.sv ----
// Register-level tests of the status flags and address mask block
module tb_i2c_status_and_address_mask;
   timeunit 1ns;
   timeprecision 100ps;

   logic                      ref_clk, srst, scl, sda, irq;
   logic                      ten_bit_mode, gc_enable, master_mode, master_rx_active;
   logic                      master_tx_begin, bus_collision, module_busy;
   logic [9:0]                own_address;
   logic [15:0]               rd_data, rv;
   logic [7:0]                tx_data;
   i2c_status_pkg::reg_req_t  req;
   int                        errors, checks;

   i2c_status_mask DUT (.ref_clk(ref_clk), .srst(srst), .bus(req), .rd_data(rd_data),
      .scl_pin(scl), .sda_pin(sda), .own_address(own_address), .ten_bit_mode(ten_bit_mode),
      .gc_enable(gc_enable), .master_mode(master_mode), .master_rx_active(master_rx_active),
      .master_tx_begin(master_tx_begin), .bus_collision(bus_collision),
      .module_busy(module_busy), .tx_data(tx_data), .irq(irq));

   i2c_bus_model m (.scl(scl), .sda(sda));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   // Leaves time for the pin synchronisers before the read
   task automatic rdv(input logic [2:0] a);
      repeat (4) @(posedge ref_clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 rv = rd_data;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input string n, input logic [2:0] a, input logic [15:0] e);
      rdv(a);
      chk(n, e, rv);
   endtask

   task automatic results();
      $display("counts errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A full run takes well under 400 us
   initial begin
      #400000;
      errors++;
      results();
   end

   initial begin
      {srst, ten_bit_mode, gc_enable, master_mode, master_rx_active} = 5'h10;
      {master_tx_begin, bus_collision, module_busy} = 3'h0;
      own_address = 10'h050;
      req = '0;
      errors = 0;
      checks = 0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h0000);
      rchk("mask", i2c_status_pkg::OFF_MASK, 16'h0000);
      rchk("unmapped", 3'h6, 16'h0000);
      wr(i2c_status_pkg::OFF_MASK, 16'hffff);
      rchk("mask", i2c_status_pkg::OFF_MASK, 16'h03ff);
      wr(i2c_status_pkg::OFF_MASK, 16'h0000);
      $display("test reset_values done");

      m.start_cond();
      m.byte_out(8'ha0, 1'b0);
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h0008);
      m.byte_out(8'ha5, 1'b0);
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h002a);
      m.byte_out(8'h5a, 1'b0);
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h006a);
      rchk("rx_hold", i2c_status_pkg::OFF_RX_HOLD, 16'h00a5);
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h0068);
      m.stop_cond();
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h0070);
      wr(i2c_status_pkg::OFF_STATUS, 16'h0000);
      rchk("status", i2c_status_pkg::OFF_STATUS, 16'h0030);
      $display("test slave_write done");

      m.start_cond();
      m.byte_out(8'ha2, 1'b0);
      m.byte_out(8'h33, 1'b0);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("rx_full", 16'h0000, rv & 16'h0002);
      wr(i2c_status_pkg::OFF_MASK, 16'h0001);
      m.start_cond();
      m.byte_out(8'ha2, 1'b0);
      m.byte_out(8'h33, 1'b0);
      rchk("rx_hold", i2c_status_pkg::OFF_RX_HOLD, 16'h0033);
      m.start_cond();
      m.byte_out(8'ha1, 1'b0);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("read_dir", 16'h0004, rv & 16'h0004);
      m.stop_cond();
      wr(i2c_status_pkg::OFF_MASK, 16'h0000);
      $display("test address_mask done");

      @(posedge ref_clk);
      gc_enable <= 1'b1;
      m.start_cond();
      m.byte_out(8'h00, 1'b0);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("gcall", 16'h0200, rv & 16'h0200);
      m.stop_cond();
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("gcall", 16'h0000, rv & 16'h0200);
      @(posedge ref_clk);
      ten_bit_mode <= 1'b1;
      own_address <= 10'h3a5;
      m.start_cond();
      m.byte_out(8'hf6, 1'b0);
      m.byte_out(8'ha5, 1'b0);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("ten_match", 16'h0100, rv & 16'h0100);
      m.stop_cond();
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("ten_match", 16'h0000, rv & 16'h0100);
      $display("test general_call_ten_bit done");

      @(posedge ref_clk);
      ten_bit_mode <= 1'b0;
      master_mode <= 1'b1;
      wr(i2c_status_pkg::OFF_TX_HOLD, 16'h003c);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("tx_full", 16'h0001, rv & 16'h0001);
      wr(i2c_status_pkg::OFF_TX_HOLD, 16'h0011);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("clash", 16'h0080, rv & 16'h0080);
      chk("tx_data", 16'h003c, {8'h00, tx_data});
      rchk("tx_hold", i2c_status_pkg::OFF_TX_HOLD, 16'h003c);
      wr(i2c_status_pkg::OFF_STATUS, 16'h0080);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("clash", 16'h0080, rv & 16'h0080);
      wr(i2c_status_pkg::OFF_STATUS, 16'h0000);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("clash", 16'h0000, rv & 16'h0080);
      @(posedge ref_clk);
      master_tx_begin <= 1'b1;
      @(posedge ref_clk);
      master_tx_begin <= 1'b0;
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("tx_active", 16'h4000, rv & 16'h4000);
      m.start_cond();
      m.byte_out(8'h3c, 1'b1);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("ack_tx", 16'h8000, rv & 16'hc001);
      @(posedge ref_clk);
      module_busy <= 1'b1;
      wr(i2c_status_pkg::OFF_TX_HOLD, 16'h0077);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("clash", 16'h0080, rv & 16'h0081);
      chk("tx_data", 16'h003c, {8'h00, tx_data});
      @(posedge ref_clk) module_busy <= 1'b0;
      m.stop_cond();
      $display("test master_transmit done");

      // Only the collision source is unmasked, so earlier events stay silent
      wr(i2c_status_pkg::OFF_IRQ_MASK, 16'h0008);
      rchk("irq_mask", i2c_status_pkg::OFF_IRQ_MASK, 16'h0008);
      @(posedge ref_clk);
      bus_collision <= 1'b1;
      @(posedge ref_clk);
      bus_collision <= 1'b0;
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("collision", 16'h0400, rv & 16'h0400);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(i2c_status_pkg::OFF_IRQ_STAT, 16'h0008);
      repeat (2) @(posedge ref_clk);
      chk("irq", 16'h0000, {15'h0000, irq});
      // Earlier start, stop, receive, overflow and clash events must survive the clear
      rchk("irq_stat", i2c_status_pkg::OFF_IRQ_STAT, 16'h0037);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("collision", 16'h0400, rv & 16'h0400);
      wr(i2c_status_pkg::OFF_STATUS, 16'h0000);
      rdv(i2c_status_pkg::OFF_STATUS);
      chk("collision", 16'h0000, rv & 16'h0400);
      $display("test collision_irq done");

      // Master receive loads every completed byte, address phase included
      @(posedge ref_clk) master_rx_active <= 1'b1;
      m.start_cond();
      m.byte_out(8'h96, 1'b0);
      rchk("rx_hold", i2c_status_pkg::OFF_RX_HOLD, 16'h0096);
      @(posedge ref_clk) master_rx_active <= 1'b0;
      m.stop_cond();
      $display("test master_receive done");
      results();
   end
endmodule // tb_i2c_status_and_address_mask
